// [hw/hdtau_pkg.sv]
// package: register map, field layout and types of the timer/address unit
package hdtau_pkg;
  localparam logic [11:0] OFF_TIMER   = 12'h130;
  localparam logic [11:0] OFF_TXADDR  = 12'h134;
  localparam logic [11:0] OFF_RXADDR  = 12'h138;
  localparam logic [11:0] OFF_RXMASK  = 12'h13C;
  localparam logic [11:0] OFF_CONTROL = 12'h150;
  localparam logic [11:0] OFF_STATUS  = 12'h154;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam int POS_CLK_SEL  = 31;
  localparam int POS_TMODE    = 30;
  localparam int POS_CNT_LSB  = 24;
  localparam int POS_CRI      = 25;
  localparam int POS_CR_BIT   = 1;
  localparam int POS_CTL_STI  = 0;
  localparam int POS_CTL_ADM  = 1;
  localparam int POS_CTL_AUTO = 2;
  localparam int POS_CTL_HDLC = 3;
  localparam int POS_CTL_CM5  = 4;
  localparam logic [2:0] CNT_ENDLESS = 3'h7;

  typedef enum logic [1:0] {
    HDTAU_IDLE = 2'b00,
    HDTAU_RUN  = 2'b01
  } hdtau_state_e;

  // received address presented by the frame receiver
  typedef struct packed {
    logic       valid;
    logic       two_byte;
    logic [7:0] high;
    logic [7:0] low;
  } hdtau_rxaddr_s;

  // address result returned to the frame receiver
  typedef struct packed {
    logic valid;
    logic match;
    logic cr_status;
  } hdtau_match_s;
endpackage : hdtau_pkg

// [hw/hdtau_unit.sv]
// protocol timer and HDLC address unit of one serial channel
`timescale 1ns/1ps
`default_nettype none
module hdtau_unit
  import hdtau_pkg::*;
(
  // clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 RESET_N,
  input  wire logic                 CLK_EN,
  // avalon-mm slave
  input  wire logic [11:0]          AVS_ADDRESS,
  input  wire logic                 AVS_READ,
  input  wire logic                 AVS_WRITE,
  input  wire logic [31:0]          AVS_WRITEDATA,
  input  wire logic [3:0]           AVS_BYTEENABLE,
  output logic [31:0]               AVS_READDATA,
  output logic                      AVS_WAITREQUEST,
  // timer clock sources (pins)
  input  wire logic                 TX_CLK_EFF,
  input  wire logic                 FRAME_SYNC_IN,
  // protocol engine
  input  wire logic                 FRAME_ACKED,
  output logic                      TIMER_IRQ,
  output logic                      POLL_REQ,
  input  wire logic                 TX_IS_COMMAND,
  output logic [15:0]               TX_ADDR_FIELD,
  output logic                      TX_ADDR_EN,
  input  wire hdtau_pkg::hdtau_rxaddr_s RX_ADDR,
  output hdtau_pkg::hdtau_match_s   RX_RESULT
);
  import hdtau_pkg::*;

  logic [31:0]  timer_register;
  logic [31:0]  tx_address_register;
  logic [31:0]  rx_address_register;
  logic [31:0]  rx_address_mask_register;
  logic [4:0]   command_register;
  logic         timer_start_command;
  logic         answered;
  hdtau_state_e state;
  logic [23:0]  ticks;
  logic [2:0]   repeats;
  logic         retry_active;
  logic [2:0]   txc_sync;
  logic [2:0]   fs_sync;
  logic         tick;
  logic         expire;

  wire timer_clock_select = timer_register[POS_CLK_SEL];
  wire timer_mode_select  = timer_register[POS_TMODE];
  wire [2:0]  repeat_count = timer_register[POS_CNT_LSB +: 3];
  wire [23:0] expiry_value = timer_register[23:0];
  wire address_size_select = command_register[POS_CTL_ADM];
  wire automode   = command_register[POS_CTL_AUTO];
  wire hdlc_on    = command_register[POS_CTL_HDLC];
  wire clk_mode5  = command_register[POS_CTL_CM5];
  wire cmd_resp_polarity = rx_address_register[POS_CRI];
  wire internal_mode = timer_mode_select && automode && hdlc_on;

  // bus side: one wait state, so read data are registered and stable
  wire req     = AVS_READ | AVS_WRITE;
  wire take    = req && answered;
  wire wr_take = take && AVS_WRITE;
  assign AVS_WAITREQUEST = req && !answered;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      answered <= 1'b0;
    end else if (CLK_EN) begin
      answered <= req && !answered;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  wire wr_timer = wr_take && AVS_ADDRESS == OFF_TIMER;
  wire wr_ctl   = wr_take && AVS_ADDRESS == OFF_CONTROL;
  wire [31:0] next_timer = merge(timer_register, AVS_WRITEDATA,
                                 AVS_BYTEENABLE) & 32'hC7FF_FFFF;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      timer_register           <= RESET_WORD;
      tx_address_register      <= RESET_WORD;
      rx_address_register      <= RESET_WORD;
      rx_address_mask_register <= RESET_WORD;
    end else if (CLK_EN && wr_take) begin
      unique case (AVS_ADDRESS)
        OFF_TIMER:  timer_register <= next_timer;
        OFF_TXADDR: tx_address_register <= merge(tx_address_register,
                      AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_FFFF;
        OFF_RXADDR: rx_address_register <= merge(rx_address_register,
                      AVS_WRITEDATA, AVS_BYTEENABLE);
        OFF_RXMASK: rx_address_mask_register <= merge(
                      rx_address_mask_register, AVS_WRITEDATA,
                      AVS_BYTEENABLE);
        default: ;
      endcase
    end
  end

  // start bit is a write-one command; it does not store
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      command_register    <= 5'h00;
      timer_start_command <= 1'b0;
    end else if (CLK_EN) begin
      timer_start_command <= wr_ctl && AVS_BYTEENABLE[0] &&
                             AVS_WRITEDATA[POS_CTL_STI];
      if (wr_ctl && AVS_BYTEENABLE[0]) begin
        command_register <= {AVS_WRITEDATA[4:1], 1'b0};
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (CLK_EN) begin
      unique case (AVS_ADDRESS)
        OFF_TIMER:   AVS_READDATA <= timer_register;
        OFF_TXADDR:  AVS_READDATA <= tx_address_register;
        OFF_RXADDR:  AVS_READDATA <= rx_address_register;
        OFF_RXMASK:  AVS_READDATA <= rx_address_mask_register;
        OFF_CONTROL: AVS_READDATA <= {27'h0, command_register};
        OFF_STATUS:  AVS_READDATA <= {repeats, 3'h0, state == HDTAU_RUN,
                                      retry_active, ticks};
        default:     AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // pin synchronisers; edge detect reads stages two and three only
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      txc_sync <= 3'h0;
      fs_sync  <= 3'h0;
    end else if (CLK_EN) begin
      txc_sync <= {txc_sync[1:0], TX_CLK_EFF};
      fs_sync  <= {fs_sync[1:0], FRAME_SYNC_IN};
    end
  end

  always_comb begin
    if (timer_clock_select) begin
      tick = clk_mode5 && fs_sync[1] && !fs_sync[2];
    end else begin
      tick = txc_sync[1] && !txc_sync[2];
    end
  end

  // expiry after value+1 ticks
  assign expire = state == HDTAU_RUN && tick && ticks == expiry_value;

  wire zero_write = wr_timer && next_timer[23:0] == 24'h000000;
  wire start = timer_start_command && !internal_mode
               && expiry_value != 24'h000000;
  // last expiry of a finite run: no restart and no further poll
  wire retries_done = expire && repeat_count != CNT_ENDLESS
                      && repeats >= repeat_count;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state   <= HDTAU_IDLE;
      ticks   <= 24'h000000;
      repeats <= 3'h0;
    end else if (CLK_EN) begin
      if (zero_write) begin
        state <= HDTAU_IDLE;
        ticks <= 24'h000000;
      end else begin
        unique case (state)
          HDTAU_IDLE: begin
            if (start || (internal_mode && retry_active)) begin
              state   <= HDTAU_RUN;
              ticks   <= 24'h000000;
              repeats <= 3'h0;
            end
          end
          HDTAU_RUN: begin
            if (internal_mode && !retry_active) begin
              state <= HDTAU_IDLE;
            end else if (expire) begin
              ticks <= 24'h000000;
              if (repeat_count == CNT_ENDLESS) begin
                state <= HDTAU_RUN;
              end else if (repeats < repeat_count) begin
                repeats <= repeats + 3'h1;
              end else begin
                state <= HDTAU_IDLE;
              end
            end else if (tick) begin
              ticks <= ticks + 24'h000001;
            end
          end
          default: state <= HDTAU_IDLE;
        endcase
      end
    end
  end

  // an unacknowledged frame keeps the automode retry timer alive
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      retry_active <= 1'b0;
    end else if (CLK_EN) begin
      if (!internal_mode || FRAME_ACKED) begin
        retry_active <= 1'b0;
      end else if (timer_start_command) begin
        retry_active <= 1'b1;
      end else if (retries_done) begin
        retry_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER_IRQ <= 1'b0;
      POLL_REQ  <= 1'b0;
    end else if (CLK_EN) begin
      TIMER_IRQ <= expire && !internal_mode;
      POLL_REQ  <= expire && internal_mode && !FRAME_ACKED
                   && !retries_done;
    end
  end

  // transmit address field, bit 1 of the high byte forced from polarity in two-byte mode
  wire [7:0] tx_address_high = tx_address_register[7:0];
  wire [7:0] tx_address_low  = tx_address_register[15:8];
  wire cr_out = TX_IS_COMMAND ? cmd_resp_polarity : !cmd_resp_polarity;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_ADDR_FIELD <= 16'h0000;
      TX_ADDR_EN    <= 1'b0;
    end else if (CLK_EN) begin
      TX_ADDR_EN <= hdlc_on;
      if (address_size_select) begin
        TX_ADDR_FIELD <= {tx_address_high[7:2], cr_out,
                          tx_address_high[0], tx_address_low};
      end else begin
        TX_ADDR_FIELD <= {8'h00, TX_IS_COMMAND ? tx_address_high
                                               : tx_address_low};
      end
    end
  end

  // receive comparison over both programmed addresses
  wire [7:0] rx_address1_high = rx_address_register[31:24];
  wire [7:0] rx_address1_low  = rx_address_register[23:16];
  wire [7:0] rx_address2_low  = rx_address_register[7:0];
  wire [7:0] rx_address2_high = rx_address_register[15:8];
  wire [7:0] hi_ign = automode ? 8'h02 : 8'h00;

  function automatic logic byte_eq(input logic [7:0] rx,
                                   input logic [7:0] ref_b,
                                   input logic [7:0] mask);
    return ((rx ^ ref_b) & ~mask) == 8'h00;
  endfunction : byte_eq

  logic m1;
  logic m2;
  always_comb begin
    if (RX_ADDR.two_byte) begin
      m1 = byte_eq(RX_ADDR.high, rx_address1_high,
                   rx_address_mask_register[15:8] | hi_ign) &&
           byte_eq(RX_ADDR.low, rx_address1_low,
                   rx_address_mask_register[7:0]);
      m2 = byte_eq(RX_ADDR.high, rx_address2_high,
                   rx_address_mask_register[31:24] | hi_ign) &&
           byte_eq(RX_ADDR.low, rx_address2_low,
                   rx_address_mask_register[23:16]);
    end else begin
      m1 = byte_eq(RX_ADDR.low, rx_address1_low,
                   rx_address_mask_register[7:0]);
      m2 = byte_eq(RX_ADDR.low, rx_address2_low,
                   rx_address_mask_register[23:16]);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RX_RESULT <= '0;
    end else if (CLK_EN) begin
      RX_RESULT.valid <= RX_ADDR.valid && hdlc_on;
      RX_RESULT.match <= m1 || m2;
      // a set C/R bit means command only when polarity is set
      RX_RESULT.cr_status <= RX_ADDR.high[POS_CR_BIT] ^
                             !cmd_resp_polarity;
    end
  end

  sequence run_expire_s;
    state == HDTAU_RUN && expire && !internal_mode;
  endsequence

  property zero_halt_p;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      CLK_EN && zero_write |=> state == HDTAU_IDLE;
  endproperty
  zero_halt_a: assert property (zero_halt_p)
    else $error("zero expiry write did not halt timer");

  ext_irq_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CLK_EN && !zero_write) ##0 run_expire_s |=> TIMER_IRQ)
    else $error("external expiry gave no interrupt");

  final_stop_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN ##0 run_expire_s ##0 repeat_count != CNT_ENDLESS
    ##0 repeats == repeat_count |=> state == HDTAU_IDLE)
    else $error("timer kept running after last restart");

  endless_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && !zero_write && state == HDTAU_RUN && expire
    && repeat_count == CNT_ENDLESS && (retry_active || !internal_mode)
    |=> state == HDTAU_RUN)
    else $error("endless mode stopped the timer");

  start_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && state == HDTAU_IDLE && start && !zero_write
    |=> state == HDTAU_RUN && ticks == 24'h000000)
    else $error("start command did not start timer");

  count_bound_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESET_N)
    state == HDTAU_RUN |-> ticks <= expiry_value)
    else $error("tick count passed the expiry value");

  cr_insert_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && address_size_select
    |=> TX_ADDR_FIELD[8 + POS_CR_BIT] ==
        ($past(TX_IS_COMMAND) == $past(cmd_resp_polarity)))
    else $error("command/response bit wrong");

  mask_all_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && hdlc_on && RX_ADDR.valid
    && rx_address_mask_register[15:0] == 16'hFFFF
    |=> RX_RESULT.match)
    else $error("fully masked address did not match");

  poll_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && expire && internal_mode && !FRAME_ACKED && !retries_done
    |=> POLL_REQ)
    else $error("no poll request at retry expiry");

  poll_limit_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && internal_mode && retries_done && !timer_start_command
    |=> !POLL_REQ && !retry_active)
    else $error("poll sent beyond the retry count");
endmodule : hdtau_unit
`default_nettype wire

// [verification/hdtau_far_end.sv]
// far-end model: transmit clock, frame sync and acknowledging engine
`timescale 1ns/1ps
`default_nettype none
module hdtau_far_end (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // acknowledge only when told and only after a poll went out
  input  wire logic ack_on,
  input  wire logic poll_req,
  // line side
  output logic      tx_clk,
  output logic      frame_sync,
  output logic      frame_acked
);
  logic [3:0] div;
  logic       seen;
  // tx clock period 8, frame sync every 16: the two sources tell apart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div        <= 4'h0;
      tx_clk     <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      div        <= div + 4'h1;
      tx_clk     <= div[2];
      frame_sync <= (div == 4'hF);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen        <= 1'b0;
      frame_acked <= 1'b0;
    end else begin
      seen        <= seen | poll_req;
      frame_acked <= ack_on & seen;
    end
  end
endmodule : hdtau_far_end
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the timer and address unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hdtau_pkg::*;
  localparam logic [31:0] HD = 32'h1 << POS_CTL_HDLC;
  localparam logic [31:0] AU = 32'h1 << POS_CTL_AUTO;
  localparam logic [31:0] AD = 32'h1 << POS_CTL_ADM;
  localparam logic [31:0] C5 = 32'h1 << POS_CTL_CM5;
  logic          clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wrq = 1'b0;
  logic [11:0]   adr = 12'h0;
  logic [31:0]   wd = 32'h0, rdata, seed = 32'h4C;
  logic [3:0]    be = 4'hF;
  logic          wait_rq, irq, poll, tx_clk, fsync, acked;
  logic          ack_on = 1'b0, cmd = 1'b0, txen, ce = 1'b1;
  logic [15:0]   txf;
  hdtau_rxaddr_s rxa = '0;
  hdtau_match_s  rxr;
  int            cyc = 0, last = 0, gap = 0, n_irq = 0, n_poll = 0;
  int            n_errors = 0, checked = 0;

  always #10 clk = ~clk;

  hdtau_unit i_dut (
    .CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(ce),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wrq),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_rq), .TX_CLK_EFF(tx_clk),
    .FRAME_SYNC_IN(fsync), .FRAME_ACKED(acked), .TIMER_IRQ(irq),
    .POLL_REQ(poll), .TX_IS_COMMAND(cmd), .TX_ADDR_FIELD(txf),
    .TX_ADDR_EN(txen), .RX_ADDR(rxa), .RX_RESULT(rxr));

  hdtau_far_end i_far (
    .clk(clk), .rst_n(rst_n), .ack_on(ack_on), .poll_req(poll),
    .tx_clk(tx_clk), .frame_sync(fsync), .frame_acked(acked));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // one-cycle pulses are counted at the edge they are sampled on
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) begin
      n_irq++;
      gap = cyc - last;
      last = cyc;
    end
    if (poll === 1'b1) n_poll++;
    if (cyc >= 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] tcfg(input logic s, m, input logic [2:0] c,
                                       input logic [23:0] v);
    return {s, m, 3'h0, c, v};
  endfunction : tcfg

  function automatic logic hit(input logic [7:0] h, l,
                               input logic [31:0] ra, mk);
    return (((h ^ ra[31:24]) & ~mk[15:8]) == 8'h0 &&
            ((l ^ ra[23:16]) & ~mk[7:0]) == 8'h0) ||
           (((h ^ ra[15:8]) & ~mk[31:24]) == 8'h0 &&
            ((l ^ ra[7:0]) & ~mk[23:16]) == 8'h0);
  endfunction : hit

  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // request stands until the edge that samples waitrequest low;
  // read data are taken at that same edge, then the request drops
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wrq <= w;
    rd  <= !w;
    wd  <= d;
    be  <= b;
    do @(posedge clk); while (wait_rq !== 1'b0);
    q = rdata;
    wrq <= 1'b0;
    rd  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a,
                     input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    check(what, q, exp);
  endtask : rdc

  task automatic run_tmr(input logic [31:0] cfg, ctl, input int n);
    wr(OFF_TIMER, cfg);
    n_irq = 0;
    n_poll = 0;
    wr(OFF_CONTROL, ctl | 32'h1);
    repeat (n) @(posedge clk);
  endtask : run_tmr

  task automatic rx_send(input logic two, input logic [7:0] h, l);
    @(posedge clk);
    rxa <= {1'b1, two, h, l};
    @(posedge clk);
    rxa.valid <= 1'b0;
    #1;
  endtask : rx_send

  initial begin
    logic [31:0] d, ra, mk, q;
    logic [7:0]  h, l;
    int          v;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    check("irq idle", {31'h0, irq}, 32'h0);
    rx_send(1'b1, 8'h12, 8'h34);
    check("rx off", {31'h0, rxr.valid}, 32'h0);
    rdc("timer rst", OFF_TIMER, RESET_WORD);
    rdc("txadr rst", OFF_TXADDR, RESET_WORD);
    rdc("rxadr rst", OFF_RXADDR, RESET_WORD);
    d = xs();
    wr(OFF_TIMER, d);
    rdc("timer rw", OFF_TIMER, d & 32'hC7FF_FFFF);
    wr(OFF_TXADDR, d & 32'h0000_FFFD);
    rdc("txadr rw", OFF_TXADDR, d & 32'h0000_FFFD);
    wr(OFF_RXADDR, d);
    bus(1'b1, OFF_RXADDR, ~d, 4'h2, q);
    rdc("rxadr lane", OFF_RXADDR, {d[31:16], ~d[15:8], d[7:0]});
    wr(12'h200, d);
    rdc("unmapped", 12'h200, 32'h0);
    wr(OFF_TIMER, 32'h0);
    for (int c = 0; c < 7; c++) begin
      v = 1 + xs() % 4;
      run_tmr(tcfg(0, 0, c[2:0], v[23:0]), HD, (c + 1) * (v + 1) * 8 + 48);
      check("irqs", 32'(n_irq), 32'(c + 1));
      if (c > 0) check("period", 32'(gap), 32'((v + 1) * 8));
    end
    run_tmr(tcfg(0, 0, CNT_ENDLESS, 24'h2), HD, 200);
    check("endless", {31'h0, n_irq >= 6}, 32'h1);
    check("endless gap", 32'(gap), 32'h18);
    wr(OFF_TIMER, tcfg(0, 0, CNT_ENDLESS, 24'h0));
    repeat (5) @(posedge clk);
    n_irq = 0;
    repeat (100) @(posedge clk);
    check("halted", 32'(n_irq), 32'h0);
    run_tmr(tcfg(1, 0, 3'h1, 24'h1), HD | C5, 112);
    check("sync irqs", 32'(n_irq), 32'h2);
    check("sync gap", 32'(gap), 32'h20);
    run_tmr(tcfg(0, 1, 3'h2, 24'h2), HD | AU, 150);
    check("polls", 32'(n_poll), 32'h2);
    check("no irq", 32'(n_irq), 32'h0);
    run_tmr(tcfg(0, 1, CNT_ENDLESS, 24'h2), HD | AU, 240);
    check("endless polls", {31'h0, n_poll >= 7}, 32'h1);
    ack_on <= 1'b1;
    repeat (30) @(posedge clk);
    n_poll = 0;
    repeat (100) @(posedge clk);
    check("acked", 32'(n_poll), 32'h0);
    wr(OFF_TIMER, 32'h0);
    ack_on <= 1'b0;
    // cri in k[0], command in k[1]; byte bits 1 chosen to suit both reads
    d = xs();
    for (int k = 0; k < 4; k++) begin
      h = {d[7:2], 1'b0, d[0]};
      wr(OFF_TXADDR, {16'h0, d[15:8], h});
      wr(OFF_RXADDR, {6'h0, k[0], 25'h0});
      wr(OFF_CONTROL, HD | AD);
      cmd <= k[1];
      repeat (3) @(posedge clk);
      #1;
      check("tx en", {31'h0, txen}, 32'h1);
      check("tx 2 byte", {16'h0, txf},
            {16'h0, d[7:2], ~(k[1] ^ k[0]), d[0], d[15:8]});
      wr(OFF_TXADDR, {16'h0, d[15:10], !k[0], d[8], d[7:2], k[0], d[0]});
      wr(OFF_CONTROL, HD);
      repeat (3) @(posedge clk);
      #1;
      check("tx 1 byte", {24'h0, txf[7:0]}, {24'h0, k[1] ?
            {d[7:2], k[0], d[0]} : {d[15:10], !k[0], d[8]}});
      wr(OFF_CONTROL, HD | AU | AD);
      wr(OFF_RXMASK, 32'h0);
      rx_send(1'b1, {6'h0, k[1], 1'b0}, 8'h0);
      check("cr match", {31'h0, rxr.match}, 32'h1);
      check("cr status", {31'h0, rxr.cr_status},
            {31'h0, k[1] ^ !k[0]});
    end
    // automode with a 1-byte field: receive high byte kept at zero
    wr(OFF_CONTROL, HD | AU);
    wr(OFF_RXADDR, {8'h00, d[23:16], 8'h00, ~d[23:16]});
    rx_send(1'b0, d[31:24], d[23:16]);
    check("1 byte hit", {31'h0, rxr.match}, 32'h1);
    rx_send(1'b0, d[31:24], d[23:16] ^ 8'h01);
    check("1 byte miss", {31'h0, rxr.match}, 32'h0);
    wr(OFF_RXMASK, 32'h0000_FFFF);
    rx_send(1'b1, d[15:8], d[7:0]);
    check("all masked", {31'h0, rxr.match}, 32'h1);
    // clock enable low: the address field must not follow the command
    @(posedge clk);
    ce  <= 1'b0;
    cmd <= 1'b0;
    repeat (3) @(posedge clk);
    check("frozen", {16'h0, txf}, {24'h0, d[7:2], 1'b1, d[0]});
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("thawed", {16'h0, txf}, {24'h0, d[15:10], 1'b0, d[8]});
    wr(OFF_CONTROL, HD | AD);
    ra = xs();
    mk = xs() & xs();
    wr(OFF_RXADDR, ra);
    wr(OFF_RXMASK, mk);
    for (int i = 0; i < 40; i++) begin
      d = xs();
      h = (i[0] ? ra[15:8] : ra[31:24]) ^ (d[7:0] & d[15:8] & d[23:16]);
      l = (i[0] ? ra[7:0] : ra[23:16]) ^ (d[31:24] & d[15:8] & d[23:16]);
      rx_send(1'b1, h, l);
      check("rx valid", {31'h0, rxr.valid}, 32'h1);
      check("rx match", {31'h0, rxr.match},
            {31'h0, hit(h, l, ra, mk)});
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
